// ---- cpu_core_register_set.sv ----
/*
  cpu_core_register_set: programming-model registers of the core.
  assumes: single ref_clk, sys_rst synchronous high, one op per request.
*/
// Function
// - data pointer is high byte over low byte, zero after reset
// - pointer read and written as sixteen bits or two bytes, same store
// - stack pointer is eight bits and resets to seven
// - push increments stack pointer first, then writes the byte
// - pop reads the top byte first, then decrements stack pointer
// - call and interrupt save return address, return restores it
// - stack accesses go to extended RAM, addressed by stack pointer
// - stack pointer zero addresses first extended RAM location
// - config bit 6 enables enhanced serial checks, resets zero
// - config bit 5 selects SPI when set, I2C when clear
// - config bit 4 enables carrier modulation on selected pins
// - config bits 1:0 reset 01, any set enables extended move
// - fetch counter resets zero, advances by instruction length, pop by fixed two
// - fetch counter not mapped, loaded by call, jump, interrupt and return
// - opcode holder captures opcode, invisible to software
// - four banks of eight bytes, bank chosen by status word
// - bank-register op takes one cycle, literal or RAM op two
// - parity flag always tracks the accumulator
// - status word holds carry, aux carry, overflow; bit addressable
// - aux register feeds multiply and divide, else scratch
// - bank select sits at status bits 4:3, value is bank number
module cpu_core_register_set (
  input  wire logic                       ref_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       clkEn,
  input  wire core_regs_pkg::sfr_req_type sfrReq,
  output logic      [15:0]                sfrRdData,
  output logic                            sfrRdValid,
  input  wire logic                       instrValid,
  input  wire core_regs_pkg::instr_type   instr,
  input  wire logic                       irqVector,
  input  wire logic [15:0]                irqAddr,
  input  wire logic [7:0]                 pushData,
  output logic                            instrReady,
  output logic      [7:0]                 popData,
  output logic                            popValid,
  output logic      [15:0]                fetchAddr,
  output logic      [15:0]                pointerValue,
  output logic      [7:0]                 mulDivOperand,
  output core_regs_pkg::config_out_type   configOut
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_SEC   = 6'b000010,
    ST_POPRD = 6'b000100,
    ST_RETHI = 6'b001000,
    ST_RETLO = 6'b010000,
    ST_PUSH2 = 6'b100000
  } phase_type;

  typedef struct packed {
    logic [7:0] result;
    logic       carry;
    logic       auxCarry;
    logic       overflow;
  } instr_sec_type;

  typedef struct packed {
    phase_type   phase;
    logic [7:0]  stackTopPointer;
    logic [7:0]  pointerLowByte;
    logic [7:0]  pointerHighByte;
    logic [7:0]  coreConfiguration;
    logic [15:0] fetchAddressCounter;
    logic [7:0]  opcodeHolder;
    logic [7:0]  statusWord;
    logic [7:0]  workingAccumulator;
    logic [7:0]  auxOperand;
    logic [15:0] rdData;
    logic        rdValid;
    logic [7:0]  popByte;
    logic        popValid;
    logic [7:0]  retHigh;
    logic [15:0] pendTarget;
    instr_sec_type pend;
  } state_type;

  state_type  s_q;
  state_type  s_d;
  logic       ramWr;
  logic [7:0] ramAddr;
  logic [7:0] ramWrData;
  logic [7:0] ramRdData;
  logic       bankWr;
  logic [7:0] bankRdData;
  logic       lowRam;
  logic [1:0] bankSel;
  logic [2:0] bankIdx;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] spStep(input logic [7:0] sp, input logic up);
    spStep = up ? sp + 8'h01 : sp - 8'h01;
  endfunction

  function automatic logic [7:0] bitWrite(input logic [7:0] v, input logic [2:0] i,
                                          input logic b);
    logic [7:0] r;
    r    = v;
    r[i] = b;
    bitWrite = r;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [7:0]  wv;
    logic [15:0] ret;
    s_d       = s_q;
    ramWr     = 1'b0;
    ramAddr   = s_q.stackTopPointer;
    ramWrData = pushData;
    bankWr    = sfrReq.write && lowRam;
    wv        = sfrReq.data[7:0];
    ret       = s_q.fetchAddressCounter + 16'(instr.length);
    s_d.rdValid  = 1'b0;
    s_d.popValid = 1'b0;
    // register port
    if (sfrReq.write)
    begin
      unique case (sfrReq.addr)
        core_regs_pkg::ADDR_STACK:
          s_d.stackTopPointer = wv;
        core_regs_pkg::ADDR_PTR_LO:
        begin
          s_d.pointerLowByte = wv;
          if (sfrReq.wide)
          begin
            s_d.pointerHighByte = sfrReq.data[15:8];
          end
        end
        core_regs_pkg::ADDR_PTR_HI:
          s_d.pointerHighByte = wv;
        core_regs_pkg::ADDR_CONFIG:
          s_d.coreConfiguration = (wv & core_regs_pkg::CFG_WRITE_MASK)
                                  | (s_q.coreConfiguration & ~core_regs_pkg::CFG_WRITE_MASK);
        core_regs_pkg::ADDR_STATUS:
          s_d.statusWord = sfrReq.bitOp
                           ? bitWrite(s_q.statusWord, sfrReq.bitIdx, sfrReq.data[0])
                           : wv;
        core_regs_pkg::ADDR_ACCUM:
          s_d.workingAccumulator = sfrReq.bitOp
                           ? bitWrite(s_q.workingAccumulator, sfrReq.bitIdx, sfrReq.data[0])
                           : wv;
        core_regs_pkg::ADDR_AUX:
          s_d.auxOperand = sfrReq.bitOp
                           ? bitWrite(s_q.auxOperand, sfrReq.bitIdx, sfrReq.data[0])
                           : wv;
        default: ;
      endcase
    end
    if (sfrReq.read)
    begin
      s_d.rdValid = 1'b1;
      unique case (sfrReq.addr)
        core_regs_pkg::ADDR_STACK:  s_d.rdData = {8'h00, s_q.stackTopPointer};
        core_regs_pkg::ADDR_PTR_LO: s_d.rdData = sfrReq.wide
                                    ? {s_q.pointerHighByte, s_q.pointerLowByte}
                                    : {8'h00, s_q.pointerLowByte};
        core_regs_pkg::ADDR_PTR_HI: s_d.rdData = {8'h00, s_q.pointerHighByte};
        core_regs_pkg::ADDR_CONFIG: s_d.rdData = {8'h00, s_q.coreConfiguration};
        core_regs_pkg::ADDR_STATUS: s_d.rdData = {8'h00, s_q.statusWord};
        core_regs_pkg::ADDR_ACCUM:  s_d.rdData = {8'h00, s_q.workingAccumulator};
        core_regs_pkg::ADDR_AUX:    s_d.rdData = {8'h00, s_q.auxOperand};
        default:                    s_d.rdData = lowRam ? {8'h00, bankRdData}
                                    : 16'h0000;
      endcase
    end
    // instruction sequencing
    unique case (s_q.phase)
      ST_IDLE:
      begin
        if (irqVector)
        begin
          s_d.stackTopPointer = spStep(s_q.stackTopPointer, 1'b1);
          s_d.retHigh         = s_q.fetchAddressCounter[15:8];
          s_d.pendTarget      = irqAddr;
          s_d.phase           = ST_PUSH2;
          ramWr               = 1'b1;
          ramAddr             = spStep(s_q.stackTopPointer, 1'b1);
          ramWrData           = s_q.fetchAddressCounter[7:0];
        end
        else if (instrValid)
        begin
          s_d.opcodeHolder = instr.opcode;
          unique case (instr.op)
            core_regs_pkg::OP_PUSH:
            begin
              s_d.stackTopPointer = spStep(s_q.stackTopPointer, 1'b1);
              ramWr     = 1'b1;
              ramAddr   = spStep(s_q.stackTopPointer, 1'b1);
              s_d.fetchAddressCounter = s_q.fetchAddressCounter + 16'(instr.length);
            end
            core_regs_pkg::OP_POP:
              s_d.phase = ST_POPRD;
            core_regs_pkg::OP_CALL:
            begin
              s_d.stackTopPointer = spStep(s_q.stackTopPointer, 1'b1);
              ramWr      = 1'b1;
              ramAddr    = spStep(s_q.stackTopPointer, 1'b1);
              ramWrData  = ret[7:0];
              s_d.retHigh    = ret[15:8];
              s_d.pendTarget = instr.target;
              s_d.phase      = ST_PUSH2;
            end
            core_regs_pkg::OP_RET:
              s_d.phase = ST_RETHI;
            core_regs_pkg::OP_JUMP:
              s_d.fetchAddressCounter = instr.target;
            core_regs_pkg::OP_ALU_REG:
            begin
              s_d.workingAccumulator = instr.aluResult;
              s_d.statusWord[core_regs_pkg::PSW_CARRY] = instr.carry;
              s_d.statusWord[core_regs_pkg::PSW_AUXC]  = instr.auxCarry;
              s_d.statusWord[core_regs_pkg::PSW_OVF]   = instr.overflow;
              s_d.fetchAddressCounter = s_q.fetchAddressCounter + 16'(instr.length);
            end
            core_regs_pkg::OP_ALU_MEM, core_regs_pkg::OP_MULDIV:
            begin
              s_d.pend  = '{instr.aluResult, instr.carry, instr.auxCarry, instr.overflow};
              s_d.pendTarget = s_q.fetchAddressCounter + 16'(instr.length);
              s_d.phase = ST_SEC;
              s_d.auxOperand = (instr.op == core_regs_pkg::OP_MULDIV)
                               ? instr.operand : s_q.auxOperand;
            end
            default:
              s_d.fetchAddressCounter = s_q.fetchAddressCounter + 16'(instr.length);
          endcase
        end
      end
      ST_SEC:
      begin
        s_d.workingAccumulator = s_q.pend.result;
        s_d.statusWord[core_regs_pkg::PSW_CARRY] = s_q.pend.carry;
        s_d.statusWord[core_regs_pkg::PSW_AUXC]  = s_q.pend.auxCarry;
        s_d.statusWord[core_regs_pkg::PSW_OVF]   = s_q.pend.overflow;
        s_d.fetchAddressCounter = s_q.pendTarget;
        s_d.phase = ST_IDLE;
      end
      ST_PUSH2:
      begin
        s_d.stackTopPointer = spStep(s_q.stackTopPointer, 1'b1);
        ramWr     = 1'b1;
        ramAddr   = spStep(s_q.stackTopPointer, 1'b1);
        ramWrData = s_q.retHigh;
        s_d.fetchAddressCounter = s_q.pendTarget;
        s_d.phase = ST_IDLE;
      end
      ST_POPRD:
      begin
        s_d.popByte  = ramRdData;
        s_d.popValid = 1'b1;
        s_d.stackTopPointer = spStep(s_q.stackTopPointer, 1'b0);
        s_d.fetchAddressCounter = s_q.fetchAddressCounter + 16'h0002;
        s_d.phase = ST_IDLE;
      end
      ST_RETHI:
      begin
        s_d.retHigh = ramRdData;
        s_d.stackTopPointer = spStep(s_q.stackTopPointer, 1'b0);
        ramAddr = spStep(s_q.stackTopPointer, 1'b0);
        s_d.phase = ST_RETLO;
      end
      ST_RETLO:
      begin
        s_d.fetchAddressCounter = {s_q.retHigh, ramRdData};
        s_d.stackTopPointer = spStep(s_q.stackTopPointer, 1'b0);
        s_d.phase = ST_IDLE;
      end
      default:
        s_d.phase = ST_IDLE;
    endcase
    s_d.statusWord[core_regs_pkg::PSW_PARITY] = ^s_d.workingAccumulator;
    if (sys_rst)
    begin
      s_d = '0;
      s_d.phase             = ST_IDLE;
      s_d.stackTopPointer   = core_regs_pkg::RST_STACK;
      {s_d.pointerHighByte, s_d.pointerLowByte} = core_regs_pkg::RST_PTR;
      s_d.coreConfiguration = core_regs_pkg::RST_CONFIG;
      s_d.fetchAddressCounter = core_regs_pkg::RST_FETCH;
      ramWr  = 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (clkEn || sys_rst)
    begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // memories
  // ---------------------------------------------------------------
  ext_stack_ram u_stack (
    .ref_clk (ref_clk),
    .clkEn   (clkEn),
    .wrEn    (ramWr),
    .addr    (ramAddr),
    .wrData  (ramWrData),
    .rdData  (ramRdData)
  );

  assign lowRam = (sfrReq.write || sfrReq.read)
                  && (sfrReq.addr <= core_regs_pkg::ADDR_BANK_END);
  assign {bankSel, bankIdx} = lowRam
      ? 5'(sfrReq.addr)
      : {s_q.statusWord[core_regs_pkg::PSW_BANK_HI:core_regs_pkg::PSW_BANK_LO], instr.regIdx};

  bank_reg_file u_banks (
    .ref_clk (ref_clk),
    .clkEn   (clkEn),
    .wrEn    (bankWr),
    .bank    (bankSel),
    .idx     (bankIdx),
    .wrData  (sfrReq.data[7:0]),
    .rdData  (bankRdData)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign sfrRdData     = s_q.rdData;
  assign sfrRdValid    = s_q.rdValid;
  assign instrReady    = (s_q.phase == ST_IDLE);
  assign popData       = s_q.popByte;
  assign popValid      = s_q.popValid;
  assign fetchAddr     = s_q.fetchAddressCounter;
  assign pointerValue  = {s_q.pointerHighByte, s_q.pointerLowByte};
  assign mulDivOperand = s_q.auxOperand;
  assign configOut.serialCheckEnhance = s_q.coreConfiguration[core_regs_pkg::CFG_SERIAL];
  assign configOut.syncPortSelect     = s_q.coreConfiguration[core_regs_pkg::CFG_SYNC];
  assign configOut.carrierModEnable   = s_q.coreConfiguration[core_regs_pkg::CFG_CARRIER];
  assign configOut.extRamMoveEnable   = s_q.coreConfiguration[core_regs_pkg::CFG_MOVE_HI]
                                      | s_q.coreConfiguration[core_regs_pkg::CFG_MOVE_LO];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  stack_reset_a: assert property ($past(sys_rst)
      |-> s_q.stackTopPointer == core_regs_pkg::RST_STACK)
    else $error("stack pointer not seven after reset");
  push_order_a: assert property (clkEn && instrReady && instrValid && !irqVector
      && instr.op == core_regs_pkg::OP_PUSH |-> ramWr && ramAddr == s_q.stackTopPointer + 8'h01)
    else $error("push wrote before increment");
  pop_order_a: assert property (clkEn && s_q.phase == ST_POPRD
      |=> popValid && s_q.stackTopPointer == $past(s_q.stackTopPointer) - 8'h01)
    else $error("pop did not decrement after read");
  parity_track_a: assert property (s_q.statusWord[core_regs_pkg::PSW_PARITY]
      == ^s_q.workingAccumulator)
    else $error("parity flag out of step");
  pointer_view_a: assert property (pointerValue[7:0] == s_q.pointerLowByte)
    else $error("pointer views disagree");
  move_enable_a: assert property (configOut.extRamMoveEnable
      == |s_q.coreConfiguration[core_regs_pkg::CFG_MOVE_HI:core_regs_pkg::CFG_MOVE_LO])
    else $error("move enable decode wrong");
  alu_mem_two_a: assert property (clkEn && instrReady && instrValid && !irqVector
      && instr.op == core_regs_pkg::OP_ALU_MEM |=> !instrReady)
    else $error("memory op did not take two cycles");
  cfg_reserved_a: assert property ((~core_regs_pkg::CFG_WRITE_MASK
      & (s_q.coreConfiguration ^ core_regs_pkg::RST_CONFIG)) == 8'h00)
    else $error("reserved config bits changed");

  push_seen_c: cover property (ramWr);
  pop_seen_c: cover property (popValid);
  ret_seen_c: cover property (s_q.phase == ST_RETLO);

endmodule

// ---- core_regs_pkg.sv ----
/*
  core_regs_pkg: shared constants and carriers for the core register set.
  assumes: single ref_clk domain, synchronous active-high reset.
*/
package core_regs_pkg;

  // ---------------------------------------------------------------
  // special register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_STACK   = 8'h81;
  localparam logic [7:0] ADDR_PTR_LO  = 8'h82;
  localparam logic [7:0] ADDR_PTR_HI  = 8'h83;
  localparam logic [7:0] ADDR_CONFIG  = 8'hAF;
  localparam logic [7:0] ADDR_STATUS  = 8'hD0;
  localparam logic [7:0] ADDR_ACCUM   = 8'hE0;
  localparam logic [7:0] ADDR_AUX     = 8'hF0;
  localparam logic [7:0] ADDR_BANK_END = 8'h1F;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_STACK   = 8'h07;
  localparam logic [15:0] RST_PTR     = 16'h0000;
  localparam logic [7:0]  RST_CONFIG  = 8'h81;
  localparam logic [15:0] RST_FETCH   = 16'h0000;
  localparam logic [7:0]  RST_BYTE    = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CFG_RSVD_HI   = 7;
  localparam int CFG_SERIAL    = 6;
  localparam int CFG_SYNC      = 5;
  localparam int CFG_CARRIER   = 4;
  localparam int CFG_MOVE_HI   = 1;
  localparam int CFG_MOVE_LO   = 0;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h73;
  localparam int PSW_CARRY     = 7;
  localparam int PSW_AUXC      = 6;
  localparam int PSW_OVF       = 2;
  localparam int PSW_PARITY    = 0;
  localparam int PSW_BANK_HI   = 4;
  localparam int PSW_BANK_LO   = 3;

  // ---------------------------------------------------------------
  // operation encodings
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE    = 4'h0,
    OP_PUSH    = 4'h1,
    OP_POP     = 4'h2,
    OP_CALL    = 4'h3,
    OP_RET     = 4'h4,
    OP_JUMP    = 4'h5,
    OP_ALU_REG = 4'h6,
    OP_ALU_MEM = 4'h7,
    OP_MULDIV  = 4'h8
  } core_op_type;

  typedef struct packed {
    logic        write;
    logic        read;
    logic        wide;
    logic        bitOp;
    logic [2:0]  bitIdx;
    logic [7:0]  addr;
    logic [15:0] data;
  } sfr_req_type;

  typedef struct packed {
    core_op_type op;
    logic [7:0]  opcode;
    logic [1:0]  length;
    logic [15:0] target;
    logic [7:0]  operand;
    logic [2:0]  regIdx;
    logic [7:0]  aluResult;
    logic        carry;
    logic        auxCarry;
    logic        overflow;
  } instr_type;

  typedef struct packed {
    logic       serialCheckEnhance;
    logic       syncPortSelect;
    logic       carrierModEnable;
    logic       extRamMoveEnable;
  } config_out_type;

endpackage

// ---- ext_stack_ram.sv ----
/*
  ext_stack_ram: extended RAM holding the stack, one byte port.
  assumes: synchronous write, registered read data.
*/
module ext_stack_ram #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          ref_clk,
  input  wire logic          clkEn,
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wrData,
  output logic      [7:0]    rdData
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0] mem [DEPTH];

  always_ff @(posedge ref_clk)
  begin
    if (clkEn)
    begin
      if (wrEn)
      begin
        mem[addr] <= wrData;
      end
      rdData <= mem[addr];
    end
  end

endmodule

// ---- bank_reg_file.sv ----
/*
  bank_reg_file: four banks of eight working bytes, lowest 32 RAM bytes.
  assumes: bank number supplied by the status word.
*/
module bank_reg_file #(
  parameter int BANKS = 4,
  parameter int REGS  = 8
) (
  input  wire logic       ref_clk,
  input  wire logic       clkEn,
  input  wire logic       wrEn,
  input  wire logic [1:0] bank,
  input  wire logic [2:0] idx,
  input  wire logic [7:0] wrData,
  output logic      [7:0] rdData
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0] regs [BANKS*REGS];
  logic [4:0] flatAddr;

  assign flatAddr = {bank, idx};
  assign rdData   = regs[flatAddr];

  always_ff @(posedge ref_clk)
  begin
    if (clkEn && wrEn)
    begin
      regs[flatAddr] <= wrData;
    end
  end

endmodule

// ---- tb_cpu_core_register_set.sv ----
/*
  tb_cpu_core_register_set: self-checking bench for the core register set.
  assumes: design files compiled first; one clock, synchronous reset.
*/
module tb_cpu_core_register_set;
  timeunit 1ns;
  timeprecision 1ns;
  // -------------------------------------------
  // signals and model state
  // -------------------------------------------
  logic                           ref_clk, sys_rst, clkEn, instrValid, irqVector;
  logic                           sfrRdValid, instrReady, popValid;
  core_regs_pkg::sfr_req_type     sfrReq;
  core_regs_pkg::instr_type       instr;
  logic [15:0]                    irqAddr, sfrRdData, fetchAddr, pointerValue, rd, d, t;
  logic [7:0]                     pushData, popData, mulDivOperand, c, sp;
  core_regs_pkg::config_out_type  configOut;
  int                             miscompares, samples_checked;
  logic [7:0]                     stk[$];
  cpu_core_register_set i_cpu_core_register_set (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .clkEn(clkEn), .sfrReq(sfrReq), .sfrRdData(sfrRdData), .sfrRdValid(sfrRdValid),
    .instrValid(instrValid), .instr(instr), .irqVector(irqVector), .irqAddr(irqAddr),
    .pushData(pushData), .instrReady(instrReady), .popData(popData), .popValid(popValid),
    .fetchAddr(fetchAddr), .pointerValue(pointerValue), .mulDivOperand(mulDivOperand),
    .configOut(configOut));
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // -------------------------------------------
  // tasks
  // -------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, seen);
      miscompares++;
    end
  endtask
  task automatic waitSig(input int sel);
    int n;
    n = 0;
    while (!(sel == 0 ? sfrRdValid === 1'b1 : sel == 1 ? instrReady === 1'b1 : popValid === 1'b1))
    begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > 20)
      begin
        miscompares++;
        summarize();
      end
    end
  endtask
  task automatic sfr(input logic wr, input logic wide, input logic [7:0] a, input logic [15:0] dt);
    @(posedge ref_clk);
    sfrReq <= '{write: wr, read: !wr, wide: wide, bitOp: 1'b0, bitIdx: 3'h0, addr: a, data: dt};
    @(posedge ref_clk);
    sfrReq <= '0;
    #1;
    if (!wr) waitSig(0);
    rd = sfrRdData;
  endtask
  task automatic op(input core_regs_pkg::core_op_type o, input logic [15:0] tg,
                    input logic [1:0] len, input logic [7:0] pb, input logic irq);
    waitSig(1);
    @(posedge ref_clk);
    if (irq) irqVector <= 1'b1;
    else instrValid <= 1'b1;
    irqAddr <= tg;
    pushData <= pb;
    instr <= '{op: o, opcode: 8'hA5, length: len, target: tg, operand: pb, regIdx: 3'h0,
               aluResult: pb, carry: 1'b0, auxCarry: 1'b0, overflow: 1'b0};
    @(posedge ref_clk);
    instrValid <= 1'b0;
    irqVector <= 1'b0;
    #1;
    if (o == core_regs_pkg::OP_ALU_REG) chk("oneCycle", {15'h0000, instrReady}, 16'h0001);
    if (o == core_regs_pkg::OP_ALU_MEM) chk("twoCycle", {15'h0000, instrReady}, 16'h0000);
    if (o == core_regs_pkg::OP_POP) waitSig(2);
    if (o == core_regs_pkg::OP_POP) chk("pop", {8'h00, popData}, {8'h00, stk.pop_back()});
    waitSig(1);
  endtask
  task automatic chkStack();
    sfr(1'b0, 1'b0, core_regs_pkg::ADDR_STACK, 16'h0000);
    chk("stack", rd, {8'h00, sp});
  endtask
  // -------------------------------------------
  // main sequence
  // -------------------------------------------
  initial
  begin
    {clkEn, instrValid, irqVector, sfrReq, instr, irqAddr, pushData} = '0;
    clkEn = 1'b1;
    sys_rst = 1'b1;
    c = 8'($urandom(32'hB473));
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    sp = 8'h07;
    chkStack();
    @(posedge ref_clk);
    clkEn <= 1'b0;
    sfr(1'b1, 1'b0, core_regs_pkg::ADDR_STACK, 16'h0055);
    @(posedge ref_clk);
    clkEn <= 1'b1;
    chkStack();
    c = 8'($urandom);
    sfr(1'b1, 1'b0, 8'h0B, {8'h00, c});
    sfr(1'b1, 1'b0, 8'h13, {8'h00, ~c});
    sfr(1'b0, 1'b0, 8'h0B, 16'h0000);
    chk("bankReg", rd, {8'h00, c});
    sfr(1'b0, 1'b1, core_regs_pkg::ADDR_PTR_LO, 16'h0000);
    chk("pointer", rd, 16'h0000);
    sfr(1'b0, 1'b0, core_regs_pkg::ADDR_CONFIG, 16'h0000);
    chk("config", rd, 16'h0081);
    chk("fetch", fetchAddr, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      d = 16'($urandom);
      c = 8'($urandom);
      sfr(1'b1, 1'b1, core_regs_pkg::ADDR_PTR_LO, d);
      sfr(1'b0, 1'b0, core_regs_pkg::ADDR_PTR_HI, 16'h0000);
      chk("ptrHigh", rd, {8'h00, d[15:8]});
      sfr(1'b1, 1'b0, core_regs_pkg::ADDR_PTR_HI, {8'h00, c});
      sfr(1'b0, 1'b1, core_regs_pkg::ADDR_PTR_LO, 16'h0000);
      chk("ptrWide", rd, {c, d[7:0]});
      chk("ptrValue", pointerValue, {c, d[7:0]});
      c = (c & core_regs_pkg::CFG_WRITE_MASK) | 8'h80;
      c[1:0] = 2'(i);
      sfr(1'b1, 1'b0, core_regs_pkg::ADDR_CONFIG, {8'h00, c});
      sfr(1'b0, 1'b0, core_regs_pkg::ADDR_CONFIG, 16'h0000);
      chk("config", rd, {8'h00, (c & 8'h73) | 8'h80});
      chk("cfgOut", 16'(configOut), 16'({c[6:4], |c[1:0]}));
    end
    sp = 8'hFF;
    sfr(1'b1, 1'b0, core_regs_pkg::ADDR_STACK, 16'h00FF);
    for (int i = 0; i < 2; i++)
    begin
      c = 8'($urandom);
      stk.push_back(c);
      sp++;
      op(core_regs_pkg::OP_PUSH, 16'h0000, 2'h1, c, 1'b0);
      chkStack();
    end
    for (int i = 0; i < 2; i++)
    begin
      sp--;
      op(core_regs_pkg::OP_POP, 16'h0000, 2'h1, 8'h00, 1'b0);
      chkStack();
    end
    t = 16'($urandom);
    op(core_regs_pkg::OP_JUMP, t, 2'h3, 8'h00, 1'b0);
    chk("jump", fetchAddr, t);
    op(core_regs_pkg::OP_ALU_REG, 16'h0000, 2'h2, 8'h00, 1'b0);
    chk("advance", fetchAddr, t + 16'h0002);
    c = 8'($urandom);
    op(core_regs_pkg::OP_ALU_MEM, 16'h0000, 2'h2, c, 1'b0);
    sfr(1'b0, 1'b0, core_regs_pkg::ADDR_ACCUM, 16'h0000);
    chk("accum", rd, {8'h00, c});
    sfr(1'b0, 1'b0, core_regs_pkg::ADDR_STATUS, 16'h0000);
    chk("status", rd, {15'h0000, ^c});
    op(core_regs_pkg::OP_MULDIV, 16'h0000, 2'h1, c ^ 8'h5A, 1'b0);
    chk("mulDiv", {8'h00, mulDivOperand}, {8'h00, c ^ 8'h5A});
    chk("advance", fetchAddr, t + 16'h0005);
    d = 16'($urandom);
    op(core_regs_pkg::OP_CALL, d, 2'h3, 8'h00, 1'b0);
    chk("call", fetchAddr, d);
    t = 16'($urandom);
    op(core_regs_pkg::OP_NONE, t, 2'h1, 8'h00, 1'b1);
    chk("vector", fetchAddr, t);
    sp = sp + 8'h04;
    chkStack();
    op(core_regs_pkg::OP_RET, 16'h0000, 2'h1, 8'h00, 1'b0);
    chk("return", fetchAddr, d);
    sp = sp - 8'h02;
    chkStack();
    sfr(1'b1, 1'b0, 8'h90, 16'h00FF);
    sfr(1'b0, 1'b0, 8'h90, 16'h0000);
    chk("unmapped", rd, 16'h0000);
    summarize();
  end
endmodule
